// [test/bit_toggle_overflow_branch_exec_tb_top.sv]
`timescale 1ns/1ps
// Drives random invert and branch words and checks the results.
module bit_toggle_overflow_branch_exec_tb_top;
  import btob_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] instr_word = 16'h0000;
  logic        instr_valid = 1'b1;
  logic [3:0]  bank_select_register = 4'h0;
  logic        ovf_flag = 1'b0;
  logic        skip_two_word = 1'b0;
  logic [7:0]  mem_rdata = 8'h00;
  logic [3:0]  mem_bank;
  logic [7:0]  mem_addr, mem_wdata, ofs;
  logic        mem_rd, mem_wr, exec_nop, pc_loaded;
  logic [20:0] pc, pc_exp;
  logic [1:0]  q_phase;
  int          miscompares = 0;
  int          checks_done = 0;
  int          dead;

  btob_core uut (
    .clk_sys              (clk_sys),
    .rst                  (rst),
    .instr_word           (instr_word),
    .instr_valid          (instr_valid),
    .bank_select_register (bank_select_register),
    .ovf_flag             (ovf_flag),
    .skip_two_word        (skip_two_word),
    .mem_rdata            (mem_rdata),
    .mem_bank             (mem_bank),
    .mem_addr             (mem_addr),
    .mem_rd               (mem_rd),
    .mem_wr               (mem_wr),
    .mem_wdata            (mem_wdata),
    .pc                   (pc),
    .q_phase              (q_phase),
    .exec_nop             (exec_nop),
    .pc_loaded            (pc_loaded)
  );

  // Free running system clock.
  always #2.5 clk_sys = ~clk_sys;

  // Expected register value after the invert.
  function automatic logic [7:0] flip(logic [7:0] d, logic [2:0] b);
    return d ^ (8'h01 << b);
  endfunction

  task automatic check(string what, logic [20:0] seen, logic [20:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    pc_exp = 21'h000000;
    dead = 0;
  endtask

  // Runs one instruction cycle of four clocks.
  task automatic op(logic [15:0] w, logic ovf, logic skp, logic vld);
    logic live, inv, br;
    live = (dead == 0);
    inv = live && vld && w[15:12] == BTOB_INV_PREFIX;
    br = live && vld && w[15:8] == BTOB_BOV_UPPER && ovf;
    check("phase", q_phase, BTOB_Q1);
    check("nop", exec_nop, !live);
    instr_word = w;
    instr_valid = vld;
    ovf_flag = ovf;
    skip_two_word = skp;
    mem_rdata = 8'($urandom);
    bank_select_register = 4'($urandom);
    @(negedge clk_sys);
    check("rd", mem_rd, inv);
    repeat (2) @(negedge clk_sys);
    check("wr", mem_wr, inv);
    if (inv)
    begin
      check("wdata", mem_wdata, flip(mem_rdata, w[11:9]));
      check("addr", mem_addr, w[7:0]);
      check("bank", mem_bank,
            w[8] ? bank_select_register : BTOB_ACCESS_BANK);
    end
    @(negedge clk_sys);
    pc_exp = pc_exp + 21'h2 + (br ? {{12{w[7]}}, w[7:0], 1'b0} : 21'h0);
    check("loaded", pc_loaded, br);
    check("pc", pc, pc_exp);
    dead = live ? (br ? 1 : (skp ? 2 : 0)) : dead - 1;
  endtask

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Trials: inverts, a branch (edge offsets in the first two trials), then a skip.
  initial
  begin
    void'($urandom(32'h20F5));
    for (int t = 0; t < 40; t++)
    begin
      do_reset();
      repeat ($urandom_range(4))
        op({4'h7, 12'($urandom)}, 1'b0, 1'b0, 1'($urandom));
      ofs = (t == 0) ? 8'h80 : ((t == 1) ? 8'h7F : 8'($urandom));
      op({BTOB_BOV_UPPER, ofs}, (t < 2) | 1'($urandom), 1'b0, 1'b1);
      repeat (2) op({4'h7, 12'($urandom)}, 1'b0, 1'b0, 1'b1);
      op(16'h0000, 1'b0, 1'b1, 1'b1);
      repeat (3) op({4'h7, 12'($urandom)}, 1'($urandom), 1'b0, 1'b1);
    end
    print_verdict();
  end

  // Cuts a hung run short.
  initial
  begin
    #100us;
    miscompares++;
    print_verdict();
  end
endmodule // bit_toggle_overflow_branch_exec_tb_top

// [test/btob_properties.sv]
`timescale 1ns/1ps
// Ties core outputs to the decoded word and the quarter phases.
module btob_properties
  import btob_pkg::*;
#(
  parameter int PC_W   = 21, // Counter width.
  parameter int BANK_W = 4   // Bank width.
)
(
  input wire logic              clk_sys,              // Clock.
  input wire logic              rst,                  // Reset.
  input wire logic [15:0]       instr_word,           // Word.
  input wire logic              instr_valid,          // Valid.
  input wire logic [BANK_W-1:0] bank_select_register, // Bank.
  input wire logic              ovf_flag,             // Overflow.
  input wire logic              skip_two_word,        // Skip.
  input wire logic [7:0]        mem_rdata,            // Read data.
  input wire logic [BANK_W-1:0] mem_bank,             // Bank out.
  input wire logic [7:0]        mem_addr,             // Address.
  input wire logic              mem_rd,               // Read.
  input wire logic              mem_wr,               // Write.
  input wire logic [7:0]        mem_wdata,            // Write data.
  input wire logic [PC_W-1:0]   pc,                   // Counter.
  input wire logic [1:0]        q_phase,              // Phase.
  input wire logic              exec_nop,             // Dead cycle.
  input wire logic              pc_loaded             // Branch done.
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Invert operation: strobes, data, address and bank.
  rd_wr_gap_a:
    assert property (mem_rd |-> q_phase == BTOB_Q2 ##2 mem_wr)
    else $error("No write after read.");
  bit_flip_a:
    assert property (mem_wr |-> (mem_wdata ^ $past(mem_rdata, 2))
      == (8'h01 << $past(instr_word[11:9], 3)))
    else $error("Wrong bit inverted.");
  inv_addr_a:
    assert property (mem_wr |-> mem_addr == $past(instr_word[7:0], 3)
      && $past(instr_word[15:12], 3) == BTOB_INV_PREFIX)
    else $error("Bad write address.");
  bank_pick_a:
    assert property (mem_wr |-> mem_bank == ($past(instr_word[8], 3)
      ? $past(bank_select_register, 3) : BTOB_ACCESS_BANK))
    else $error("Bad bank.");

  // Overflow branch and two-word skip: decision, target and dead cycles.
  ovf_take_a:
    assert property (q_phase == BTOB_Q4 && !exec_nop && $past(instr_valid, 3)
      && $past(instr_word[15:8], 3) == BTOB_BOV_UPPER
      |=> pc_loaded == $past(ovf_flag))
    else $error("Branch decision wrong.");
  br_target_a:
    assert property (pc_loaded |-> pc == PC_W'($past(pc, 4) + PC_W'(2)
      + {{(PC_W-9){$past(instr_word[7], 4)}}, $past(instr_word[7:0], 4),
      1'b0}))
    else $error("Branch target wrong.");
  br_dead_a:
    assert property (pc_loaded |-> exec_nop [*4] ##1 !exec_nop)
    else $error("Branch dead cycle length wrong.");
  skip_dead_a:
    assert property (q_phase == BTOB_Q4 && skip_two_word && !exec_nop
      |=> exec_nop [*8] ##1 !exec_nop)
    else $error("Skip dead cycles wrong.");

  // Main scenarios reached.
  cover property (pc_loaded);
  cover property (mem_wr && mem_bank == BTOB_ACCESS_BANK);
  cover property (q_phase == BTOB_Q4 && skip_two_word && !exec_nop);
endmodule // btob_properties

bind btob_core btob_properties #(
  .PC_W   (PC_W),
  .BANK_W (BANK_W)
) u_prop (
  .clk_sys              (clk_sys),
  .rst                  (rst),
  .instr_word           (instr_word),
  .instr_valid          (instr_valid),
  .bank_select_register (bank_select_register),
  .ovf_flag             (ovf_flag),
  .skip_two_word        (skip_two_word),
  .mem_rdata            (mem_rdata),
  .mem_bank             (mem_bank),
  .mem_addr             (mem_addr),
  .mem_rd               (mem_rd),
  .mem_wr               (mem_wr),
  .mem_wdata            (mem_wdata),
  .pc                   (pc),
  .q_phase              (q_phase),
  .exec_nop             (exec_nop),
  .pc_loaded            (pc_loaded)
);

// [verilog/btob_core.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Bit invert flips the chosen bit of the register, keeps other bits.
// - Access-select 0 forces access bank; 1 uses the bank select register.
// - Bit invert word is 0111, 3-bit index, access bit, 8-bit address.
// - Overflow branch word has upper byte 11100100 and a signed offset.
// - Overflow set loads incremented counter plus twice offset; else next.
// - Offset is 8-bit two's complement, doubled, added to advanced counter.
// - Taken branch: two cycles, PC written in Q4, then one dead cycle.
module btob_core
  import btob_pkg::*;
#(
  parameter int PC_W   = 21,   // Program counter width in bits.
  parameter int BANK_W = 4     // Bank number width in bits.
)
(
  input  wire logic              clk_sys,       // System clock.
  input  wire logic              rst,           // Synchronous reset.
  input  wire logic [15:0]       instr_word,    // Fetched instruction word.
  input  wire logic              instr_valid,   // Word valid for this cycle.
  input  wire logic [BANK_W-1:0] bank_select_register, // Bank select value.
  input  wire logic              ovf_flag,      // Arithmetic overflow flag.
  input  wire logic              skip_two_word, // Skip over a 2-word op taken.
  input  wire logic [7:0]        mem_rdata,     // Data read from memory.
  output logic [BANK_W-1:0]      mem_bank,      // Bank of the access.
  output logic [7:0]             mem_addr,      // Register address.
  output logic                   mem_rd,        // Read strobe in Q2.
  output logic                   mem_wr,        // Write strobe in Q4.
  output logic [7:0]             mem_wdata,     // Data to write.
  output logic [PC_W-1:0]        pc,            // Program counter.
  output logic [1:0]             q_phase,       // Current quarter phase.
  output logic                   exec_nop,      // Cycle runs as no operation.
  output logic                   pc_loaded      // Branch wrote the counter.
);

  logic               q4_end;
  btob_state_t        st_q;
  btob_state_t        st_d;
  logic [1:0]         nop_cnt_q;
  logic [1:0]         nop_cnt_d;
  logic [15:0]        ir_q;
  logic               ir_ok_q;
  logic [7:0]         data_q;
  logic [PC_W-1:0]    pc_q;
  logic [PC_W-1:0]    pc_d;
  logic [BANK_W-1:0]  bank_q;
  logic [7:0]         addr_q;
  logic [7:0]         wdata_q;
  logic               wr_q;
  logic               rd_q;
  logic               loaded_q;

  btob_qphase u_qphase (
    .clk_sys (clk_sys),
    .rst     (rst),
    .q_phase (q_phase),
    .q4_end  (q4_end)
  );

  // Phase qualifiers for the edges that end Q1, Q2 and Q3.
  wire at_q1_end = (q_phase == BTOB_Q1);
  wire at_q2_end = (q_phase == BTOB_Q2);
  wire at_q3_end = (q_phase == BTOB_Q3);
  wire exec_live = (st_q == BTOB_EXEC);

  // Decode of the word arriving at the end of Q1; the read in Q2 and its
  // address need it before the instruction register holds it.
  wire       new_inv  = instr_valid && exec_live &&
    instr_word[15:BTOB_INV_PFX_LSB] == BTOB_INV_PREFIX;
  wire       new_acc  = instr_word[BTOB_INV_ACC_POS];
  wire [7:0] reg_addr = instr_word[BTOB_INV_ACC_POS-1:BTOB_ADDR_LSB];

  // Decode of the latched word, used from Q2 up to the end of Q4.
  wire        is_inv   = ir_ok_q && exec_live &&
    ir_q[15:BTOB_INV_PFX_LSB] == BTOB_INV_PREFIX;
  wire        is_bov   = ir_ok_q && exec_live &&
    ir_q[15:BTOB_BOV_UP_LSB] == BTOB_BOV_UPPER;
  wire [2:0]  bit_idx  = ir_q[BTOB_INV_PFX_LSB-1:BTOB_INV_BIT_LSB];
  wire [7:0]  ofs      = ir_q[BTOB_BOV_UP_LSB-1:BTOB_OFS_LSB];
  wire        take_bov = is_bov && ovf_flag;

  // Bank choice for the data access; a clear access bit overrides the
  // bank select value with the fixed access bank.
  wire [BANK_W-1:0] acc_bank = BANK_W'(BTOB_ACCESS_BANK);
  wire [BANK_W-1:0] bank_sel = new_acc ? bank_select_register
                                       : acc_bank;

  // Inverted data: one bit flipped, others kept.
  wire [7:0] bit_mask  = 8'h01 << bit_idx;
  wire [7:0] inv_data  = data_q ^ bit_mask;

  // Incremented counter and sign-extended doubled offset.
  wire [PC_W-1:0] pc_inc  = pc_q + PC_W'(2);
  wire [PC_W-1:0] ofs_x2  = {{(PC_W-9){ofs[7]}}, ofs, 1'b0};
  wire [PC_W-1:0] pc_tgt  = pc_inc + ofs_x2;

  // Counter: advance each cycle, or load the target when the branch is taken.
  assign pc_d = take_bov ? pc_tgt : pc_inc;

  // Dead cycle scheduling after a taken branch or a long skip. A taken
  // branch wins over a skip that is flagged in the same cycle.
  always_comb
  begin
    st_d      = st_q;
    nop_cnt_d = nop_cnt_q;
    unique case (st_q)
      BTOB_FLUSH:
      begin
        nop_cnt_d = nop_cnt_q - 2'h1;
        if (nop_cnt_q == 2'h1)
          st_d = BTOB_EXEC;
      end
      BTOB_EXEC:
      begin
        if (take_bov)
        begin
          st_d      = BTOB_FLUSH;
          nop_cnt_d = BTOB_BRANCH_NOPS;
        end
        else if (skip_two_word)
        begin
          st_d      = BTOB_FLUSH;
          nop_cnt_d = BTOB_SKIP2_NOPS;
        end
      end
    endcase
  end

  // Instruction register, taken at the end of Q1.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ir_q    <= 16'h0000;
      ir_ok_q <= 1'b0;
    end
    else if (at_q1_end)
    begin
      ir_q    <= instr_word;
      ir_ok_q <= instr_valid;
    end
  end

  // Read data of an invert, taken at the end of Q2.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      data_q <= 8'h00;
    else if (at_q2_end && is_inv)
      data_q <= mem_rdata;
  end

  // Strobes: the read stands in Q2, the write back stands in Q4.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end
    else
    begin
      rd_q <= new_inv && at_q1_end;
      wr_q <= is_inv && at_q3_end;
    end
  end

  // Bank and address of the access, set together with the read strobe.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      bank_q <= BANK_W'(BTOB_ACCESS_BANK);
      addr_q <= 8'h00;
    end
    else if (new_inv && at_q1_end)
    begin
      bank_q <= bank_sel;
      addr_q <= reg_addr;
    end
  end

  // Write data with the chosen bit inverted, ready for the Q4 write.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      wdata_q <= 8'h00;
    else if (is_inv && at_q3_end)
      wdata_q <= inv_data;
  end

  // Counter and dead cycle state, both advanced at the end of Q4.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pc_q      <= BTOB_PC_RESET[PC_W-1:0];
      st_q      <= BTOB_EXEC;
      nop_cnt_q <= 2'h0;
    end
    else if (q4_end)
    begin
      pc_q      <= pc_d;
      st_q      <= st_d;
      nop_cnt_q <= nop_cnt_d;
    end
  end

  // Branch pulse for the first clock after the counter load.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      loaded_q <= 1'b0;
    else
      loaded_q <= q4_end && take_bov;
  end

  // Output wiring.
  assign mem_bank  = bank_q;
  assign mem_addr  = addr_q;
  assign mem_rd    = rd_q;
  assign mem_wr    = wr_q;
  assign mem_wdata = wdata_q;
  assign pc        = pc_q;
  assign exec_nop  = (st_q == BTOB_FLUSH);
  assign pc_loaded = loaded_q;

endmodule // btob_core

// [verilog/btob_pkg.sv]
package btob_pkg;

  // Opcode layout of the bit invert word.
  localparam logic [3:0] BTOB_INV_PREFIX  = 4'h7;
  localparam int         BTOB_INV_PFX_LSB = 12;
  localparam int         BTOB_INV_BIT_LSB = 9;
  localparam int         BTOB_INV_ACC_POS = 8;
  localparam int         BTOB_ADDR_LSB    = 0;

  // Opcode layout of the overflow branch word.
  localparam logic [7:0] BTOB_BOV_UPPER   = 8'hE4;
  localparam int         BTOB_BOV_UP_LSB  = 8;
  localparam int         BTOB_OFS_LSB     = 0;

  // Access bank value forced when the access-select bit is clear.
  localparam logic [3:0] BTOB_ACCESS_BANK = 4'h0;

  // Quarter phase count per instruction cycle.
  localparam int         BTOB_QUARTERS    = 4;
  localparam logic [1:0] BTOB_Q1          = 2'h0;
  localparam logic [1:0] BTOB_Q2          = 2'h1;
  localparam logic [1:0] BTOB_Q3          = 2'h2;
  localparam logic [1:0] BTOB_Q4          = 2'h3;

  // Dead cycles after a taken branch and after a skip over two words.
  localparam logic [1:0] BTOB_BRANCH_NOPS = 2'h1;
  localparam logic [1:0] BTOB_SKIP2_NOPS  = 2'h2;

  // Program counter reset value.
  localparam logic [20:0] BTOB_PC_RESET   = 21'h000000;

  // Execution state of one instruction cycle.
  typedef enum logic [0:0] {
    BTOB_EXEC,
    BTOB_FLUSH
  } btob_state_t;

endpackage

// [verilog/btob_qphase.sv]
`timescale 1ns/1ps
// Divides the system clock into the four quarter phases of a cycle.
module btob_qphase
  import btob_pkg::*;
(
  input  wire logic       clk_sys,   // System clock.
  input  wire logic       rst,       // Synchronous reset, active high.
  output logic [1:0]      q_phase,   // Current quarter phase.
  output logic            q4_end     // Pulse on the last quarter.
);

  logic [1:0] q_q;
  logic [1:0] q_d;

  // Advance the phase counter, wrapping after the fourth quarter.
  assign q_d = q_q + 2'h1;
  assign q_phase = q_q;
  assign q4_end = (q_q == BTOB_Q4);

  // Phase register.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      q_q <= BTOB_Q1;
    else
      q_q <= q_d;
  end

endmodule // btob_qphase
